/* File: pkg/abs_pkg.sv */
/*
  Constants and carrier types for the adaptive boost supervisor.
  Assumes a single 50 MHz core clock and an analog stage that reports
  sink headroom and feedback comparator levels as plain logic levels.
*/
package abs_pkg;
  localparam int SINK_N = 6;
  localparam int TGT_W = 10;
  localparam logic [TGT_W-1:0] TGT_MIN = 10'h000;
  localparam logic [TGT_W-1:0] TGT_MAX = 10'h3ff;
  localparam int INIT_PCT = 88;
  localparam logic [TGT_W-1:0] TGT_INIT =
    TGT_W'(int'(TGT_MIN) + (int'(TGT_MAX) - int'(TGT_MIN)) * INIT_PCT / 100);
  localparam int CLK_NS = 20;
  localparam int SAMPLE_NS = 10000;
  localparam int SAMPLE_CYC = (SAMPLE_NS / CLK_NS < 1) ? 1 : SAMPLE_NS / CLK_NS;
  localparam int UV_TIMEOUT_MS = 110;
  localparam int UV_TIMEOUT_CYC = UV_TIMEOUT_MS * 1000000 / CLK_NS;
  localparam int UV_CNT_W = 23;
  localparam int SAMPLE_CNT_W = 10;
  // Flag vector positions
  localparam int FLAG_OVL = 0;
  localparam int FLAG_OVH = 1;
  localparam int FLAG_OCP = 2;
  localparam logic [SINK_N-1:0] MASK_ALL = 6'h3f;

  typedef enum logic {LOOP_INIT, LOOP_ADAPT} abs_loop_t;

  // Feedback comparator levels, as seen on the pins
  typedef struct packed {
    logic output_limit_low_event;
    logic output_limit_high_event;
    logic output_under_event;
  } abs_fb_t;

  typedef struct packed {
    logic boost_overcurrent_flag;
    logic boost_overvolt_high_flag;
    logic boost_overvolt_low_flag;
  } abs_flags_t;

  // Configuration code to set of used sink outputs
  function automatic logic [SINK_N-1:0] cfg_mask(input logic [2:0] code);
    unique case (code)
      3'h0: cfg_mask = 6'h3f;
      3'h1: cfg_mask = 6'h1f;
      3'h2: cfg_mask = 6'h0f;
      3'h3: cfg_mask = 6'h07;
      3'h4: cfg_mask = 6'h03;
      default: cfg_mask = MASK_ALL; // Grouped strings use every output
    endcase
  endfunction
endpackage

/* File: hw/abs_uv_timer.sv */
/*
  Undervoltage overcurrent timer: counts while the undervoltage level
  stands and pulses once at expiry. Assumes run is already synchronous.
*/
`timescale 1ns/1ps
module abs_uv_timer import abs_pkg::*; #(
  parameter int unsigned TIMEOUT_CYC = UV_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic run,
  output logic expired
);
  logic [UV_CNT_W-1:0] cnt_q;
  logic done_q;

  // Count up while run holds; any gap restarts the full interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 23'h000000;
    end else if (!run) begin
      cnt_q <= 23'h000000;
    end else if (cnt_q != UV_CNT_W'(TIMEOUT_CYC)) begin
      cnt_q <= cnt_q + 23'h000001;
    end
  end

  // One pulse per undervoltage episode, not one per cycle past expiry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= run && (cnt_q == UV_CNT_W'(TIMEOUT_CYC));
    end
  end

  assign expired = run && (cnt_q == UV_CNT_W'(TIMEOUT_CYC)) && !done_q;
endmodule // abs_uv_timer

/* File: hw/abs_supervisor.sv */
/*
  Adaptive boost supervisor: headroom-driven boost target, overvoltage
  and undervoltage handling, sticky status flags.
  Assumes comparator and headroom levels arrive from the analog stage
  asynchronously; config code, fault mask and clears come from logic
  on CLK.
*/
`timescale 1ns/1ps
module abs_supervisor import abs_pkg::*; #(
  parameter int unsigned UV_TIMEOUT = UV_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Configuration and LED driver state
  input wire logic [2:0] STRING_CONFIG_SELECT,
  input wire logic [SINK_N-1:0] STRING_FAULT,
  input wire logic LED_ACTIVE,
  // Analog comparators (asynchronous)
  input wire logic [SINK_N-1:0] SINK_BELOW_HEADROOM,
  input wire abs_fb_t FEEDBACK_NODE,
  // Recovery handshake and software clears
  input wire logic RECOVERY_DONE,
  input wire abs_flags_t FLAG_CLEAR,
  // Outputs to the power stage
  output logic [TGT_W-1:0] BOOST_TARGET,
  output logic SWITCH_EN,
  output logic FAULT_RECOVERY,
  // Status
  output abs_flags_t STATUS_FLAGS
);
  localparam int SYNC_W = SINK_N + 3;

  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [SYNC_W-1:0] sync_in;
  logic [SINK_N-1:0] below_s, monitored;
  abs_fb_t fb_s;
  abs_loop_t loop_q;
  logic [SAMPLE_CNT_W-1:0] tick_cnt_q;
  logic tick;
  logic [TGT_W-1:0] tgt_q;
  logic sw_en_q, fault_q, uv_expired;
  abs_flags_t flags_q;
  logic any_low;

  // Pin levels gathered in synchroniser order: sinks low, feedback high
  assign sync_in = {FEEDBACK_NODE, SINK_BELOW_HEADROOM};

  // Two-stage synchronisers, one per comparator bit
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= sync_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign below_s = sync2_q[SINK_N-1:0];
  assign fb_s = abs_fb_t'(sync2_q[SYNC_W-1:SINK_N]);

  // Only configured, healthy strings steer the loop
  assign monitored = cfg_mask(STRING_CONFIG_SELECT) & ~STRING_FAULT;
  assign any_low = |(below_s & monitored);

  // Sample tick; a slow loop keeps steps behind the analog settling time
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_q <= 10'h000;
    end else if (tick) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end
  assign tick = (tick_cnt_q == SAMPLE_CNT_W'(SAMPLE_CYC - 1));

  // Loop mode: adapt only while the LED drivers run
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      loop_q <= LOOP_INIT;
    end else begin
      unique case (loop_q)
        LOOP_INIT: if (LED_ACTIVE) loop_q <= LOOP_ADAPT;
        LOOP_ADAPT: if (!LED_ACTIVE) loop_q <= LOOP_INIT;
      endcase
    end
  end

  // Boost target stepping
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tgt_q <= TGT_INIT;
    end else if (loop_q == LOOP_INIT) begin
      tgt_q <= TGT_INIT;
    end else if (tick) begin
      if (any_low && tgt_q != TGT_MAX) begin
        tgt_q <= tgt_q + 10'h001;
      end else if (!any_low && tgt_q != TGT_MIN) begin
        tgt_q <= tgt_q - 10'h001;
      end
    end
  end

  // Undervoltage timer; a gap in the comparator restarts it
  abs_uv_timer #(.TIMEOUT_CYC(UV_TIMEOUT)) u_uv_timer (
    .clk(CLK),
    .arst_n(ARST_N),
    .run(fb_s.output_under_event && !fault_q),
    .expired(uv_expired)
  );

  // Fault recovery latch, released by the recovery sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_q <= 1'b0;
    end else if (fb_s.output_limit_high_event || uv_expired) begin
      fault_q <= 1'b1;
    end else if (RECOVERY_DONE) begin
      fault_q <= 1'b0;
    end
  end

  // Gate switching; LED drivers are not touched by overvoltage-low
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sw_en_q <= 1'b0;
    end else begin
      sw_en_q <= !fb_s.output_limit_low_event && !fb_s.output_limit_high_event
                 && !fault_q && !uv_expired;
    end
  end

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_q <= '0;
    end else begin
      flags_q.boost_overvolt_low_flag <= fb_s.output_limit_low_event
        || (flags_q.boost_overvolt_low_flag && !FLAG_CLEAR.boost_overvolt_low_flag);
      flags_q.boost_overvolt_high_flag <= fb_s.output_limit_high_event
        || (flags_q.boost_overvolt_high_flag && !FLAG_CLEAR.boost_overvolt_high_flag);
      flags_q.boost_overcurrent_flag <= uv_expired
        || (flags_q.boost_overcurrent_flag && !FLAG_CLEAR.boost_overcurrent_flag);
    end
  end

  assign BOOST_TARGET = tgt_q;
  assign SWITCH_EN = sw_en_q;
  assign FAULT_RECOVERY = fault_q;
  assign STATUS_FLAGS = flags_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_init_level_hold: assert property (loop_q == LOOP_INIT |=> tgt_q == TGT_INIT)
    else $error("target left initial level before drivers active");
  a_adapt_after_on: assert property (!LED_ACTIVE ##1 !LED_ACTIVE |=> tgt_q == TGT_INIT)
    else $error("target adapted with drivers off");
  a_step_up_low: assert property (loop_q == LOOP_ADAPT && tick && any_low && tgt_q != TGT_MAX
      |=> tgt_q == $past(tgt_q) + 10'h001)
    else $error("target did not step up");
  a_step_down_ok: assert property (loop_q == LOOP_ADAPT && tick && !any_low && tgt_q != TGT_MIN
      |=> tgt_q == $past(tgt_q) - 10'h001)
    else $error("target did not step down");
  a_mask_unused: assert property (loop_q == LOOP_ADAPT && tick && tgt_q != TGT_MIN
      && (below_s & cfg_mask(STRING_CONFIG_SELECT)) == 6'h00
      |=> tgt_q == $past(tgt_q) - 10'h001)
    else $error("unused output steered loop");
  a_fault_masked: assert property (&STRING_FAULT |-> !any_low)
    else $error("faulted string steered loop");
  a_ovl_stop_sw: assert property (fb_s.output_limit_low_event
      |=> !SWITCH_EN && flags_q.boost_overvolt_low_flag)
    else $error("switching not stopped on overvoltage low");
  a_ovl_resume: assert property (!fb_s.output_limit_low_event && !fb_s.output_limit_high_event
      && !fault_q && !uv_expired |=> SWITCH_EN)
    else $error("switching did not resume");
  a_ovh_recovery: assert property (fb_s.output_limit_high_event
      |=> fault_q && flags_q.boost_overvolt_high_flag)
    else $error("overvoltage high not handled");
  a_uv_expiry_ocp: assert property (uv_expired |=> fault_q && flags_q.boost_overcurrent_flag)
    else $error("undervoltage expiry not handled");
  a_uv_cancel: assert property (!fb_s.output_under_event |=> !uv_expired)
    else $error("timer fired after undervoltage cleared");
  a_flag_sticky: assert property (flags_q.boost_overcurrent_flag
      && !FLAG_CLEAR.boost_overcurrent_flag |=> flags_q.boost_overcurrent_flag)
    else $error("flag lost without clear");
endmodule // abs_supervisor

/* File: test/abs_stage_model.sv */
/*
  Model of the analog boost stage: sink headroom and feedback comparators.
  Assumes the bench sets string demand and comparator commands on CLK.
*/
`timescale 1ns/1ps
module abs_stage_model import abs_pkg::*; (
  // Clock
  input wire logic clk,
  // Target from the supervisor, demand from the bench
  input wire logic [TGT_W-1:0] target,
  input wire logic [TGT_W-1:0] need,
  input wire logic [SINK_N-1:0] hot,
  input wire abs_fb_t fb_cmd,
  // Comparator levels
  output logic [SINK_N-1:0] below,
  output abs_fb_t fb
);
  // Quiet comparators until the first edge
  initial begin
    below = '0;
    fb = '0;
  end

  // Hot strings starve while the target is short of their need; lag models the analog path
  always @(posedge clk) begin
    below <= #2 (target < need) ? hot : '0;
    fb <= #2 fb_cmd;
  end
endmodule // abs_stage_model

/* File: test/adaptive_boost_supervisor_tb.sv */
/*
  Self-checking bench for the boost supervisor with a short undervoltage timer.
  Assumes the analog stage model above and a 50 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h seen %h", nm, e, s); end end
module adaptive_boost_supervisor_tb import abs_pkg::*;;
  localparam int UVT = 20;
  logic CLK, ARST_N, led, rdone, sw, fr;
  logic [2:0] cfg;
  logic [SINK_N-1:0] fault, hot, below;
  logic [TGT_W-1:0] need, target, t0;
  abs_fb_t fbc, fb;
  abs_flags_t clr, flags;
  int n_errors, checks, i;

  abs_supervisor #(.UV_TIMEOUT(UVT)) i_abs_supervisor (.CLK(CLK), .ARST_N(ARST_N),
    .STRING_CONFIG_SELECT(cfg), .STRING_FAULT(fault), .LED_ACTIVE(led),
    .SINK_BELOW_HEADROOM(below), .FEEDBACK_NODE(fb), .RECOVERY_DONE(rdone),
    .FLAG_CLEAR(clr), .BOOST_TARGET(target), .SWITCH_EN(sw), .FAULT_RECOVERY(fr),
    .STATUS_FLAGS(flags));
  abs_stage_model i_abs_stage_model (.clk(CLK), .target(target), .need(need), .hot(hot),
    .fb_cmd(fbc), .below(below), .fb(fb));

  // Clock
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end

  // Inputs move a fixed 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    n_errors = 0;
    checks = 0;
    ARST_N = 0;
    cfg = 3'h0;
    fault = '0;
    led = 0;
    rdone = 0;
    clr = '0;
    need = '0;
    hot = '0;
    fbc = '0;
    cyc(6);
    `CHK("init target", TGT_INIT, target)
    `CHK("reset flags", 3'h0, flags)
    ARST_N = 1;
    // Starving strings must not move the target before the drivers run
    hot = 6'h3f;
    need = 10'h3ff;
    cyc(1200);
    `CHK("idle target", TGT_INIT, target)
    // One live string needing just under the start level: settle and dither
    led = 1;
    hot = 6'h01;
    need = TGT_INIT - 10'h2;
    cyc(3000);
    `CHK("dither", 1'b1, target == need || target == need - 10'h1)
    // Two-string config, output 5 unused, output 0 faulted: nothing monitored starves
    cfg = 3'h4;
    hot = 6'h21;
    fault = 6'h01;
    need = 10'h3ff;
    t0 = target;
    cyc(1600);
    `CHK("step down", 1'b1, target <= t0 - 10'h3 && target >= t0 - 10'h4)
    fault = '0;
    t0 = target;
    cyc(1600);
    `CHK("step up", 1'b1, target >= t0 + 10'h3 && target <= t0 + 10'h4)
    led = 0;
    cyc(3);
    `CHK("back to init", TGT_INIT, target)
    hot = '0;
    // Overvoltage low: switching pauses, flag sticks
    fbc.output_limit_low_event = 1;
    cyc(4);
    `CHK("ovl switch", 1'b0, sw)
    `CHK("ovl flag", 3'h1, flags)
    `CHK("ovl no recovery", 1'b0, fr)
    fbc = '0;
    cyc(4);
    `CHK("ovl resume", 1'b1, sw)
    `CHK("ovl sticky", 3'h1, flags)
    clr = 3'h1;
    cyc(1);
    clr = '0;
    cyc(1);
    `CHK("ovl cleared", 3'h0, flags)
    // Overvoltage high: fault recovery until released
    fbc.output_limit_high_event = 1;
    cyc(4);
    `CHK("ovh recovery", 1'b1, fr)
    `CHK("ovh flag", 3'h2, flags)
    `CHK("ovh switch", 1'b0, sw)
    fbc = '0;
    cyc(4);
    rdone = 1;
    clr = 3'h2;
    cyc(1);
    rdone = 0;
    clr = '0;
    cyc(2);
    `CHK("ovh released", 1'b0, fr)
    `CHK("ovh cleared", 3'h0, flags)
    // Two short undervoltage bursts together exceed the limit but must not trip
    repeat (2) begin
      fbc.output_under_event = 1;
      cyc(UVT - 5);
      fbc = '0;
      cyc(3);
    end
    `CHK("uv restart", 3'h0, flags)
    `CHK("uv no recovery", 1'b0, fr)
    // Persistent undervoltage trips after the full interval
    fbc.output_under_event = 1;
    for (i = 0; i < UVT + 20 && fr !== 1'b1; i++)
      cyc(1);
    if (i >= UVT + 20) begin
      n_errors++;
      $display("BAD uv timeout exp 1 seen %h", fr);
    end else begin
      `CHK("uv delay", 1'b1, i >= UVT && i <= UVT + 6)
      `CHK("uv flag", 3'h4, flags)
    end
    conclude();
  end
endmodule // adaptive_boost_supervisor_tb
